//--- sss_core.sv
// sss_core: select-line synchronous serial channel, master or slave
// assumes a 16-bit register port; select and clock pins sampled through synchronisers, data_in sampled directly
`timescale 1ns/10ps
module sss_core
  import sss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [15:0]      reg_rdata,
  input  wire logic        select_input_n,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  output logic             data_out,
  output logic             data_out_oe,
  input  wire logic        data_in,
  output logic             tx_irq,
  output logic             rx_irq
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } sss_state_t;
  typedef struct packed {
    sss_state_t  state;
    logic [7:0]  tx_buf;
    logic        tx_empty;
    logic [7:0]  tx_sh;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_buf;
    logic        rx_full;
    logic        ovr;
    logic [3:0]  bit_cnt;
    logic        sclk;
    logic        dout;
    logic        dout_oe;
    logic        sclk_oe;
    logic        fault;
    logic        rx_armed;
    logic        sel_q;
    logic        ck_q;
    logic [7:0]  brg;
    logic [7:0]  mode;
    logic [7:0]  c0;
    logic [5:0]  c1;
    logic [3:0]  s3;
    logic [3:0]  pre;
    logic        txi;
    logic        rxi;
    logic [15:0] rdata;
  } sss_core_t;
  sss_core_t st_reg, st_next;
  logic sel_n_s;
  logic ck_s;
  logic half_tick;
  logic slave;
  logic select_line_function_on;
  logic pol;
  logic ph;
  logic lsb;
  logic te;
  logic re;
  logic load_ok;
  logic sel_act;
  logic edge_lead;
  logic edge_trail;
  logic nxt_bit;
  sss_sync #(.W(1)) u_sel_sync (
    .clk     (clk),
    .resetn  (resetn),
    .d       (select_input_n),
    .rst_val (1'b1),
    .q       (sel_n_s)
  );
  sss_sync #(.W(1)) u_ck_sync (
    .clk     (clk),
    .resetn  (resetn),
    .d       (serial_clock_pin_in),
    .rst_val (1'b1),
    .q       (ck_s)
  );
  assign slave = st_reg.s3[S3_MS_BIT];
  assign select_line_function_on   = st_reg.s3[S3_SSE_BIT];
  assign pol   = st_reg.c0[C0_POL_BIT];
  assign ph    = st_reg.s3[S3_PH_BIT];
  assign lsb   = st_reg.c0[C0_ORDER_BIT];
  assign te    = st_reg.c1[C1_TE_BIT];
  assign re    = st_reg.c1[C1_RE_BIT];
  sss_divider u_div (
    .clk                   (clk),
    .resetn                (resetn),
    .run                   (st_reg.state == ST_SHIFT && !slave),
    .src_sel               (st_reg.c0[C0_CLKSEL_LO +: 2]),
    .prescale_divide_field (st_reg.pre),
    .bit_rate_divider      (st_reg.brg),
    .half_tick             (half_tick)
  );
  always_comb begin
    st_next = st_reg;
    st_next.txi = 1'b0;
    st_next.rxi = 1'b0;
    st_next.sel_q = sel_n_s;
    st_next.ck_q = ck_s;
    st_next.rdata = 16'h0000;
    load_ok = te && !st_reg.tx_empty;
    // with the select function on, slave sees clock only with select low; master loses bus on low
    sel_act = !select_line_function_on || (slave ? !sel_n_s : sel_n_s);
    edge_lead = 1'b0;
    edge_trail = 1'b0;
    if (slave) begin
      if (!select_line_function_on || !sel_n_s) begin
        // leading edge is the drive edge: falling for pol 0
        edge_lead  = (st_reg.ck_q != ck_s) && (ck_s == pol);
        edge_trail = (st_reg.ck_q != ck_s) && (ck_s != pol);
      end
    end else if (half_tick) begin
      edge_lead  = (st_reg.sclk != pol);
      edge_trail = (st_reg.sclk == pol);
    end
    nxt_bit = lsb ? st_reg.tx_sh[1] : st_reg.tx_sh[6];
    // register port
    if (reg_write) begin
      case (reg_addr)
        ADDR_TX_BUFFER: begin
          st_next.tx_buf = reg_wdata[7:0];
          st_next.tx_empty = 1'b0;
        end
        ADDR_BIT_RATE: st_next.brg = reg_wdata[7:0];
        ADDR_MODE:     st_next.mode = reg_wdata[7:0];
        ADDR_CTRL0:    st_next.c0 = reg_wdata[7:0];
        ADDR_CTRL1: begin
          st_next.c1[C1_TE_BIT]  = reg_wdata[C1_TE_BIT];
          st_next.c1[C1_RE_BIT]  = reg_wdata[C1_RE_BIT];
          st_next.c1[C1_IRS_BIT] = reg_wdata[C1_IRS_BIT];
          st_next.c1[C1_RRM_BIT] = reg_wdata[C1_RRM_BIT];
        end
        ADDR_SMR3: begin
          st_next.s3 = reg_wdata[3:0];
          // fault clears only while select is high
          if (!reg_wdata[S3_ERR_BIT] && sel_n_s)
            st_next.fault = 1'b0;
        end
        ADDR_PRESCALE: st_next.pre = reg_wdata[3:0];
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        ADDR_RX_BUFFER: begin
          st_next.rdata = {3'h0, st_reg.ovr, 4'h0, st_reg.rx_buf};
          st_next.rx_full = 1'b0;
          st_next.ovr = 1'b0;
          if (st_reg.c1[C1_RRM_BIT])
            st_next.rx_armed = 1'b1;
        end
        ADDR_BIT_RATE: st_next.rdata = 16'h0000;
        ADDR_MODE:     st_next.rdata = {8'h00, st_reg.mode};
        ADDR_CTRL0: begin
          st_next.rdata = {8'h00, st_reg.c0};
          st_next.rdata[C0_TXEPT_BIT] = (st_reg.state == ST_IDLE);
        end
        ADDR_CTRL1: begin
          st_next.rdata = {10'h000, st_reg.c1};
          st_next.rdata[C1_TI_BIT] = st_reg.tx_empty;
          st_next.rdata[C1_RI_BIT] = st_reg.rx_full;
        end
        ADDR_SMR3: st_next.rdata = {11'h000, st_reg.fault, st_reg.s3};
        ADDR_PRESCALE: st_next.rdata = {12'h000, st_reg.pre};
        default: st_next.rdata = 16'h0000;
      endcase
    end
    // select line: master fault and pin enables
    if (select_line_function_on && !slave && !sel_n_s)
      st_next.fault = 1'b1;
    st_next.sclk_oe = !slave && !st_next.fault;
    if (slave)
      st_next.dout_oe = !select_line_function_on || !sel_n_s;
    else
      st_next.dout_oe = !st_next.fault;
    case (st_reg.state)
      ST_IDLE: begin
        // clock rests away from the drive level: high for polarity 0
        st_next.sclk = !pol;
        st_next.bit_cnt = 4'h0;
        if (load_ok && sel_act && (!slave || ck_s == !pol)) begin
          st_next.state = ST_SHIFT;
          st_next.tx_sh = st_reg.tx_buf;
          // a buffer write in the same cycle keeps the new word pending
          if (!(reg_write && reg_addr == ADDR_TX_BUFFER))
            st_next.tx_empty = 1'b1;
          st_next.rx_armed = re;
          st_next.txi = !st_reg.c1[C1_IRS_BIT];
          // phase 1: first bit presented at start, no clock delay
          st_next.dout = lsb ? st_reg.tx_buf[0] : st_reg.tx_buf[7];
        end else if (st_reg.rx_armed && re && te && sel_act && slave) begin
          // continuous receive: shift out the last frame again
          st_next.state = ST_SHIFT;
          st_next.tx_sh = st_reg.tx_buf;
        end
      end
      ST_SHIFT: begin
        if (!slave && half_tick)
          st_next.sclk = !st_reg.sclk;
        if (!slave && select_line_function_on && !sel_n_s) begin
          st_next.state = ST_IDLE;
        end else if (edge_lead && (ph ? st_reg.bit_cnt != 4'h0 : 1'b1)) begin
          // phase 0 drives on every leading edge
          if (ph)
            st_next.dout = nxt_bit;
          else
            st_next.dout = lsb ? st_reg.tx_sh[0] : st_reg.tx_sh[7];
          if (ph)
            st_next.tx_sh = lsb ? {1'b0, st_reg.tx_sh[7:1]}
                                : {st_reg.tx_sh[6:0], 1'b0};
        end else if (edge_trail) begin
          st_next.rx_sh = lsb ? {data_in, st_reg.rx_sh[7:1]}
                              : {st_reg.rx_sh[6:0], data_in};
          if (!ph)
            st_next.tx_sh = lsb ? {1'b0, st_reg.tx_sh[7:1]}
                                : {st_reg.tx_sh[6:0], 1'b0};
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          if (st_reg.bit_cnt == 4'(OVR_BIT_INDEX) && st_reg.rx_full
              && st_reg.rx_armed)
            st_next.ovr = 1'b1;
          if (st_reg.bit_cnt == 4'(FRAME_BITS - 1))
            st_next.state = ST_DONE;
        end
      end
      ST_DONE: begin
        st_next.state = ST_IDLE;
        st_next.sclk = !pol;
        st_next.txi = st_reg.c1[C1_IRS_BIT];
        if (st_reg.rx_armed) begin
          st_next.rx_buf = st_reg.rx_sh;
          if (!st_reg.ovr) begin
            st_next.rx_full = 1'b1;
            st_next.rxi = 1'b1;
          end
          st_next.rx_armed = st_reg.c1[C1_RRM_BIT];
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.tx_empty <= 1'b1;
      st_reg.sel_q <= 1'b1;
      st_reg.ck_q <= 1'b1;
      st_reg.sclk <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  assign reg_rdata            = st_reg.rdata;
  assign serial_clock_pin_out = st_reg.sclk;
  assign serial_clock_pin_oe  = st_reg.sclk_oe;
  assign data_out             = st_reg.dout;
  assign data_out_oe          = st_reg.dout_oe;
  assign tx_irq               = st_reg.txi;
  assign rx_irq               = st_reg.rxi;
  property p_fault_set;
    @(posedge clk) disable iff (!resetn)
      (select_line_function_on && !slave && !sel_n_s) |=> st_reg.fault;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault flag not set on select low");
  property p_fault_float;
    @(posedge clk) disable iff (!resetn)
      (st_reg.fault && !slave && !$past(slave)) |->
        !serial_clock_pin_oe && !data_out_oe;
  endproperty
  a_fault_float: assert property (p_fault_float)
    else $error("pins driven during fault");
  property p_slave_float;
    @(posedge clk) disable iff (!resetn)
      (slave && select_line_function_on && sel_n_s) |=> !data_out_oe;
  endproperty
  a_slave_float: assert property (p_slave_float)
    else $error("slave drives with select high");
  property p_start;
    @(posedge clk) disable iff (!resetn)
      (st_reg.state == ST_IDLE && st_next.state == ST_SHIFT) |->
        te && (!st_reg.tx_empty || st_reg.rx_armed);
  endproperty
  a_start: assert property (p_start)
    else $error("transfer started without tx enable");
  property p_frame;
    @(posedge clk) disable iff (!resetn)
      (st_reg.state == ST_DONE) |-> $past(st_reg.bit_cnt) == 4'h7;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame not eight bits");
  property p_rxirq;
    @(posedge clk) disable iff (!resetn)
      rx_irq |-> st_reg.rx_full && !st_reg.ovr;
  endproperty
  a_rxirq: assert property (p_rxirq)
    else $error("rx request without complete flag");
  property p_txirq;
    @(posedge clk) disable iff (!resetn)
      (tx_irq && $past(st_reg.c1[C1_IRS_BIT])) |->
        $past(st_reg.state) == ST_DONE;
  endproperty
  a_txirq: assert property (p_txirq)
    else $error("tx request not at shift end");
  property p_master_clk;
    @(posedge clk) disable iff (!resetn)
      (slave) |=> !serial_clock_pin_oe;
  endproperty
  a_master_clk: assert property (p_master_clk)
    else $error("slave drives clock pin");
  c_frame: cover property (@(posedge clk) st_reg.state == ST_DONE);
  c_fault: cover property (@(posedge clk) st_reg.fault);
  c_ovr:   cover property (@(posedge clk) st_reg.ovr);
endmodule // sss_core

//--- sss_divider.sv
// sss_divider: count source select, 2n prescaler and bit rate divider
// assumes clk is the system clock; emits a one-cycle tick per half period
`timescale 1ns/10ps
module sss_divider
  import sss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [1:0] src_sel,
  input  wire logic [3:0] prescale_divide_field,
  input  wire logic [7:0] bit_rate_divider,
  output logic            half_tick
);
  typedef struct packed {
    logic [6:0] pre_cnt;
    logic [7:0] brg_cnt;
    logic       tick;
  } sss_div_t;
  sss_div_t st_reg, st_next;
  logic [6:0] pre_lim;
  logic       src_tick;
  always_comb begin
    pre_lim = 7'h00;
    case (src_sel)
      2'h0:    pre_lim = 7'h00;
      2'h1:    pre_lim = 7'h07;
      default: pre_lim = (prescale_divide_field == 4'h0) ? 7'h00 :
                 7'({prescale_divide_field, 1'b0} - 5'h01);
    endcase
    src_tick = (st_reg.pre_cnt >= pre_lim);
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.pre_cnt = 7'h00;
      st_next.brg_cnt = 8'h00;
    end else if (src_tick) begin
      st_next.pre_cnt = 7'h00;
      // divide by 2(m+1): m+1 source ticks per half period
      if (st_reg.brg_cnt >= bit_rate_divider) begin
        st_next.brg_cnt = 8'h00;
        st_next.tick = 1'b1;
      end else begin
        st_next.brg_cnt = st_reg.brg_cnt + 8'h01;
      end
    end else begin
      st_next.pre_cnt = st_reg.pre_cnt + 7'h01;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign half_tick = st_reg.tick;
endmodule // sss_divider

//--- sss_partner.sv
// sss_partner: far-side serial peer; listens as slave on master frames
// and makes the clock as master on slave frames; bench resolves wires
`timescale 1ns/10ps
module sss_partner (
  input  wire logic       sclk,
  input  wire logic       dout,
  input  wire logic       dout_oe,
  input  wire logic       pol,
  input  wire logic       lsb,
  input  wire logic [7:0] tx_byte,
  output logic            din,
  output logic            mclk,
  output logic            mclk_oe,
  output logic [7:0]      rx_byte,
  output int              edges,
  output realtime         t1,
  output realtime         t2
);
  int nd;
  int ns;

  task automatic clear();
    edges = 0;
    nd = 0;
    ns = 0;
    rx_byte = 8'h00;
  endtask

  // clock enters at its idle level before any frame
  task automatic drive(input logic on);
    mclk = ~pol;
    mclk_oe = on;
  endtask

  task automatic run_master(input int half);
    for (int k = 0; k < 8; k++) begin
      #(half) mclk = pol;
      #(half) mclk = ~pol;
    end
  endtask

  initial begin
    din = 1'b0;
    t1 = 0;
    t2 = 0;
    drive(1'b0);
    clear();
  end

  // drive on the edge leaving idle, sample on the return to idle
  always @(sclk) begin
    if (sclk === ~pol) begin
      if (ns < 8)
        rx_byte[lsb ? ns : 7 - ns] = dout_oe ? dout : 1'bx;
      ns++;
    end else if (sclk === pol) begin
      if (nd < 8)
        din = tx_byte[lsb ? nd : 7 - nd];
      nd++;
    end
    edges++;
    if (edges == 2)
      t1 = $realtime;
    if (edges == 3)
      t2 = $realtime;
  end
endmodule // sss_partner

//--- sss_pkg.sv
// sss_pkg: register map, field positions and reset values for the
// select-line serial channel; assumes a 16-bit plain register port
package sss_pkg;
  localparam logic [3:0] ADDR_TX_BUFFER = 4'h0;
  localparam logic [3:0] ADDR_RX_BUFFER = 4'h1;
  localparam logic [3:0] ADDR_BIT_RATE  = 4'h2;
  localparam logic [3:0] ADDR_MODE      = 4'h3;
  localparam logic [3:0] ADDR_CTRL0     = 4'h4;
  localparam logic [3:0] ADDR_CTRL1     = 4'h5;
  localparam logic [3:0] ADDR_SMR3      = 4'h6;
  localparam logic [3:0] ADDR_PRESCALE  = 4'h7;
  // mode register
  localparam int MODE_CLKSRC_BIT = 3;
  // control 0
  localparam int C0_CLKSEL_LO    = 0;
  localparam int C0_TXEPT_BIT    = 3;
  localparam int C0_POL_BIT      = 6;
  localparam int C0_ORDER_BIT    = 7;
  // control 1
  localparam int C1_TE_BIT       = 0;
  localparam int C1_TI_BIT       = 1;
  localparam int C1_RE_BIT       = 2;
  localparam int C1_RI_BIT       = 3;
  localparam int C1_IRS_BIT      = 4;
  localparam int C1_RRM_BIT      = 5;
  // special mode 3
  localparam int S3_SSE_BIT      = 0;
  localparam int S3_PH_BIT       = 1;
  localparam int S3_MS_BIT       = 3;
  localparam int S3_ERR_BIT      = 4;
  // rx buffer upper byte
  localparam int RB_OER_BIT      = 12;
  localparam int FRAME_BITS      = 8;
  localparam int OVR_BIT_INDEX   = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] BIT_CNT_W  = 4'h0;
endpackage

//--- sss_sync.sv
// sss_sync: two-stage synchroniser for pin levels
// assumes inputs may be asynchronous to clk
`timescale 1ns/10ps
module sss_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic [W-1:0]      q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sss_syn_t;
  sss_syn_t st_reg, st_next;
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q = st_reg.s2;
endmodule // sss_sync

//--- sync_serial_select_mode_tb.sv
// sync_serial_select_mode_tb: register-port bench for sss_core
// assumes sss_partner on the far side of the serial pins
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  num_errors++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module sync_serial_select_mode_tb
  import sss_pkg::*;
;
  logic        clk;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_rdata;
  logic        sel_n;
  logic        sclk_w;
  logic        sclk_last;
  logic        clk_out;
  logic        clk_oe;
  logic        dout;
  logic        dout_oe;
  logic        din;
  logic        tx_irq;
  logic        rx_irq;
  logic        pol;
  logic        lsb;
  logic        irs;
  logic [7:0]  p_tx;
  logic        mclk;
  logic        mclk_oe;
  logic [7:0]  p_rx;
  int          edges;
  realtime     t1;
  realtime     t2;
  int          num_errors;
  int          cmp_count;
  int          n_tx;
  int          n_rx;
  int          e_at;
  int          m;
  int          n;
  int          hc;
  logic [31:0] seed;
  logic [15:0] rdv;
  logic [7:0]  tb;
  logic [7:0]  pb;
  logic [7:0]  exp_q[$];

  // released clock line shows a level that changes every cycle
  assign sclk_w = clk_oe ? clk_out : (mclk_oe ? mclk : ~sclk_last);

  sss_core uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .select_input_n(sel_n),
    .serial_clock_pin_in(sclk_w), .serial_clock_pin_out(clk_out),
    .serial_clock_pin_oe(clk_oe), .data_out(dout),
    .data_out_oe(dout_oe), .data_in(din), .tx_irq(tx_irq),
    .rx_irq(rx_irq));

  sss_partner p (.sclk(sclk_w), .dout(dout), .dout_oe(dout_oe),
    .pol(pol), .lsb(lsb), .tx_byte(p_tx), .din(din), .mclk(mclk),
    .mclk_oe(mclk_oe), .rx_byte(p_rx), .edges(edges), .t1(t1),
    .t2(t2));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    sclk_last <= sclk_w;
    if (tx_irq === 1'b1) begin
      if (n_tx == 0)
        e_at = edges;
      n_tx++;
    end
    if (rx_irq === 1'b1)
      n_rx++;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rdv = reg_rdata;
  endtask

  task automatic cfg(input logic [1:0] src);
    wr(ADDR_MODE, 16'h0000);
    wr(ADDR_CTRL0, {8'h00, lsb, pol, 4'h0, src});
    wr(ADDR_PRESCALE, 16'(n));
    wr(ADDR_BIT_RATE, 16'(m));
    wr(ADDR_SMR3, {15'h0000, irs});
  endtask

  task automatic xfer(input bit ovr);
    int post;
    p_tx = pb;
    p.clear();
    n_tx = 0;
    n_rx = 0;
    post = 0;
    wr(ADDR_CTRL1, {10'h000, 1'b0, irs, 4'h4});
    exp_q.push_back(tb);
    wr(ADDR_TX_BUFFER, {8'h00, tb});
    repeat (50) @(posedge clk);
    `CHK(edges, 0)
    wr(ADDR_CTRL1, {10'h000, 1'b0, irs, 4'h5});
    for (int k = 0; k < 8000 && post < 64; k++) begin
      @(posedge clk);
      if (edges >= 16)
        post++;
    end
    if (post < 64) begin
      num_errors++;
      conclude();
    end
    `CHK(edges, 16)
    `CHK(n_tx, 1)
    `CHK(irs ? (e_at >= 15) : (e_at == 0), 1'b1)
    `CHK(n_rx, ovr ? 0 : 1)
    `CHK(p_rx, exp_q.pop_front())
    `CHK(int'(t2 - t1), 10 * hc)
  endtask

  task automatic pick();
    tb = 8'(xs());
    pb = 8'(xs());
  endtask

  initial begin
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sel_n = 1'b1;
    sclk_last = 1'b1;
    seed = 32'd78511;
    pol = 1'b0;
    lsb = 1'b0;
    irs = 1'b1;
    p_tx = 8'h00;
    num_errors = 0;
    cmp_count = 0;
    n_tx = 0;
    n_rx = 0;
    e_at = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    wr(4'h8, 16'hFFFF);
    rd(4'h8);
    `CHK(rdv, 16'h0000)
    rd(ADDR_CTRL1);
    `CHK(rdv, 16'h0002)
    for (int i = 0; i < 4; i++) begin
      pol = i[0];
      lsb = i[1];
      irs = (i != 3);
      m = 2 + xs() % 3;
      n = 1 + xs() % 3;
      hc = (m + 1) * ((i == 0) ? 1 : (i == 1) ? 8 : 2 * n);
      cfg(i[1:0]);
      pick();
      xfer(1'b0);
      rd(ADDR_RX_BUFFER);
      `CHK(rdv[7:0], pb)
    end
    irs = 1'b1;
    for (int j = 0; j < 2; j++) begin
      pick();
      xfer(j == 1);
    end
    rd(ADDR_RX_BUFFER);
    `CHK(rdv[RB_OER_BIT], 1'b1)
    rd(ADDR_RX_BUFFER);
    `CHK(rdv[RB_OER_BIT], 1'b0)
    wr(ADDR_SMR3, 16'h0000);
    sel_n <= 1'b0;
    repeat (6) @(posedge clk);
    rd(ADDR_SMR3);
    `CHK(rdv[S3_ERR_BIT], 1'b0)
    wr(ADDR_SMR3, 16'h0001);
    repeat (6) @(posedge clk);
    `CHK(clk_oe, 1'b0)
    `CHK(dout_oe, 1'b0)
    wr(ADDR_SMR3, 16'h0001);
    rd(ADDR_SMR3);
    `CHK(rdv[S3_ERR_BIT], 1'b1)
    sel_n <= 1'b1;
    repeat (6) @(posedge clk);
    wr(ADDR_SMR3, 16'h0001);
    rd(ADDR_SMR3);
    `CHK(rdv[S3_ERR_BIT], 1'b0)
    repeat (4) @(posedge clk);
    `CHK(clk_oe, 1'b1)
    pick();
    xfer(1'b0);
    rd(ADDR_RX_BUFFER);
    `CHK(rdv[7:0], pb)
    pol = 1'b0;
    lsb = 1'b1;
    wr(ADDR_MODE, 16'h0008);
    wr(ADDR_CTRL0, 16'h0080);
    wr(ADDR_SMR3, 16'h0009);
    wr(ADDR_CTRL1, 16'h0015);
    p.drive(1'b1);
    pick();
    p_tx = pb;
    exp_q.push_back(tb);
    wr(ADDR_TX_BUFFER, {8'h00, tb});
    p.clear();
    n_rx = 0;
    p.run_master(80);
    `CHK(dout_oe, 1'b0)
    `CHK(clk_oe, 1'b0)
    `CHK(n_rx, 0)
    sel_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(dout_oe, 1'b1)
    p.clear();
    p.run_master(80);
    repeat (40) @(posedge clk);
    `CHK(n_rx, 1)
    `CHK(p_rx, exp_q.pop_front())
    rd(ADDR_RX_BUFFER);
    `CHK(rdv[7:0], pb)
    sel_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(dout_oe, 1'b0)
    wr(ADDR_SMR3, 16'h000B);
    pick();
    wr(ADDR_TX_BUFFER, {8'h00, tb});
    sel_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(dout_oe, 1'b1)
    `CHK(dout, tb[0])
    sel_n <= 1'b1;
    repeat (6) @(posedge clk);
    conclude();
  end
endmodule // sync_serial_select_mode_tb
